// ===== logic/enc_pkg.sv
// Constants and register map for the incremental encoder input block.
// Function
// - Pulses per turn 1..65535, reset 1024
// - Loss action fields: A 1:0, B 3:2, Z 5:4
// - Action 0 with cable loss raises fault
// - Action 1 with cable loss raises alarm only
// - Action 2 disables detection for channel
// - Homing bit zeroes turns and fraction on index
// - Homing bit clears itself when done
// - Sense 0: A leading B is forward
// - Sense 1: B leading A is forward
// - Settings word resets to zero
package enc_pkg;
    localparam logic [11:0] ppt_off = 12'h000;
    localparam logic [11:0] opt_off = 12'h004;
    localparam logic [11:0] frac_off = 12'h008;
    localparam logic [11:0] turns_off = 12'h00c;
    localparam logic [11:0] stat_off = 12'h010;
    localparam logic [11:0] mask_off = 12'h014;
    localparam logic [11:0] loss_off = 12'h018;
    localparam logic [15:0] ppt_reset = 16'h0400;
    localparam logic [7:0] opt_reset = 8'h00;
    localparam int home_bit = 6;
    localparam int sense_bit = 7;
    localparam logic [1:0] act_fault = 2'h0;
    localparam logic [1:0] act_alarm = 2'h1;
    localparam logic [1:0] act_off = 2'h2;
    // Status bits: 0 homed, 1 fault raised, 2 alarm raised, 3 turn wrap.
    localparam int ev_homed = 0;
    localparam int ev_fault = 1;
    localparam int ev_alarm = 2;
    localparam int ev_wrap = 3;
    localparam int ev_num = 4;
endpackage

// ===== logic/quad_decoder.sv
// Quadrature step decoder with selectable forward sense.
`timescale 1ns/10ps
module quad_decoder (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Encoder channels and sense
    input wire logic chan_a,
    input wire logic chan_b,
    input wire logic sense_ba,
    // Decoded steps
    output logic step_fwd,
    output logic step_rev
);
    logic [1:0] prev_r;
    logic up;
    logic dn;
    logic moved;

    // Remember last phase pair to detect a transition.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 2'h0;
        end else begin
            prev_r <= {chan_a, chan_b};
        end
    end

    // A leading B follows 00,10,11,01; a step forward leaves new A unlike old B.
    // Only a single channel change is a step, so double changes are dropped.
    always_comb begin
        moved = (chan_a ^ prev_r[1]) ^ (chan_b ^ prev_r[0]);
        up = moved && (chan_a ^ prev_r[0]);
        dn = moved && !(chan_a ^ prev_r[0]);
        step_fwd = sense_ba ? dn : up;
        step_rev = sense_ba ? up : dn;
    end
endmodule

// ===== logic/encoder_input.sv
// Incremental encoder input with APB registers, homing and cable-loss actions.
`timescale 1ns/10ps
module encoder_input import enc_pkg::*; #(
    parameter int ppt_width = 16,
    parameter int turn_width = 32
) (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Encoder channels
    input wire logic chan_a,
    input wire logic chan_b,
    input wire logic chan_z,
    // Cable loss indications, bit 0 A, 1 B, 2 Z
    input wire logic [2:0] cable_loss,
    // Condition outputs
    output logic fault_o,
    output logic alarm_o,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [ppt_width-1:0] ppt_r;
    logic [7:0] opt_r;
    logic [ppt_width-1:0] frac_r;
    logic [turn_width-1:0] turns_r;
    logic [ev_num-1:0] stat_r;
    logic [ev_num-1:0] mask_r;
    logic [2:0] fault_ch;
    logic [2:0] alarm_ch;
    logic z_prev_r;
    logic z_rise;
    logic step_fwd;
    logic step_rev;
    logic do_home;
    logic wrap_ev;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] rd_nxt;
    logic [ev_num-1:0] ev_set;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    ////////////////////////////////////////////////////////////////////////
    // Step decoder.
    quad_decoder u_dec (
        .pclk(pclk),
        .presetn(presetn),
        .chan_a(chan_a),
        .chan_b(chan_b),
        .sense_ba(opt_r[sense_bit]),
        .step_fwd(step_fwd),
        .step_rev(step_rev)
    );

    // Index edge detection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            z_prev_r <= 1'b0;
        end else begin
            z_prev_r <= chan_z;
        end
    end
    assign z_rise = chan_z && !z_prev_r;
    assign do_home = opt_r[home_bit] && z_rise;

    ////////////////////////////////////////////////////////////////////////
    // Loss actions per channel; codes 2 and 3 raise nothing.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_loss
            assign fault_ch[gi] = cable_loss[gi] && (opt_r[2*gi +: 2] == act_fault);
            assign alarm_ch[gi] = cable_loss[gi] && (opt_r[2*gi +: 2] == act_alarm);
        end
    endgenerate

    // Fault and alarm are levels following the enabled loss inputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_o <= 1'b0;
            alarm_o <= 1'b0;
        end else begin
            fault_o <= |fault_ch;
            alarm_o <= |alarm_ch;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Position counting; homing overrides any step in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frac_r <= '0;
            turns_r <= '0;
        end else if (do_home) begin
            frac_r <= '0;
            turns_r <= '0;
        end else if (step_fwd) begin
            if (frac_r + 1'b1 >= ppt_r) begin
                frac_r <= '0;
                turns_r <= turns_r + 1'b1;
            end else begin
                frac_r <= frac_r + 1'b1;
            end
        end else if (step_rev) begin
            if (frac_r == '0) begin
                frac_r <= ppt_r - 1'b1;
                turns_r <= turns_r - 1'b1;
            end else begin
                frac_r <= frac_r - 1'b1;
            end
        end
    end
    assign wrap_ev = (step_fwd && !do_home && (frac_r + 1'b1 >= ppt_r))
        || (step_rev && !do_home && (frac_r == '0));

    ////////////////////////////////////////////////////////////////////////
    // Pulses per turn; zero writes are refused to keep the range 1..65535.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ppt_r <= ppt_reset;
        end else if (wr_en && paddr == ppt_off && pwdata[ppt_width-1:0] != '0) begin
            ppt_r <= pwdata[ppt_width-1:0];
        end
    end

    // Settings word; homing clear by hardware wins over a software write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_r <= opt_reset;
        end else begin
            if (wr_en && paddr == opt_off) begin
                opt_r <= pwdata[7:0];
            end
            if (do_home) begin
                opt_r[home_bit] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status with write-one-to-clear; new events win over the clear.
    assign ev_set = {wrap_ev, (|alarm_ch) && !alarm_o, (|fault_ch) && !fault_o, do_home};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= '0;
        end else if (wr_en && paddr == stat_off) begin
            stat_r <= (stat_r & ~pwdata[ev_num-1:0]) | ev_set;
        end else begin
            stat_r <= stat_r | ev_set;
        end
    end

    // Interrupt mask.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= '0;
        end else if (wr_en && paddr == mask_off) begin
            mask_r <= pwdata[ev_num-1:0];
        end
    end

    // Interrupt level from registered status.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_r & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux.
    always_comb begin
        rd_nxt = 32'h0000_0000;
        addr_ok = 1'b1;
        unique case (paddr)
            ppt_off: rd_nxt[ppt_width-1:0] = ppt_r;
            opt_off: rd_nxt[7:0] = opt_r;
            frac_off: rd_nxt[ppt_width-1:0] = frac_r;
            turns_off: rd_nxt[turn_width-1:0] = turns_r;
            stat_off: rd_nxt[ev_num-1:0] = stat_r;
            mask_off: rd_nxt[ev_num-1:0] = mask_r;
            loss_off: rd_nxt[2:0] = cable_loss;
            default: addr_ok = 1'b0;
        endcase
    end

    // Zero-wait answer: pready and data registered in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0000_0000;
        end
    end
endmodule

// ===== bench/enc_checker_asserts.sv
// Port checker for the encoder input block.
`timescale 1ns/10ps
module enc_checker import enc_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Loss and conditions
    input wire logic [2:0] cable_loss,
    input wire logic fault_o,
    input wire logic alarm_o
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Each setup cycle is answered in the next cycle, and only then.
    property p_ans; psel && !penable |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer after setup");
    property p_only; pready |-> psel && penable && $past(psel && !penable); endproperty
    a_only: assert property (p_only) else $error("answer outside access");
    property p_err; pslverr |-> pready && (paddr > loss_off || paddr[1:0] != 2'h0); endproperty
    a_err: assert property (p_err) else $error("error on mapped word");
    property p_map; pready && paddr <= loss_off && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
    a_map: assert property (p_map) else $error("mapped word refused");
    property p_idle; !pready |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside answer");
    // Conditions only follow a loss indication.
    property p_fault; $rose(fault_o) |-> $past(|cable_loss); endproperty
    a_fault: assert property (p_fault) else $error("fault without loss");
    property p_alarm; $rose(alarm_o) |-> $past(|cable_loss); endproperty
    a_alarm: assert property (p_alarm) else $error("alarm without loss");
    property p_quiet; !(|cable_loss) [*2] |-> !fault_o && !alarm_o; endproperty
    a_quiet: assert property (p_quiet) else $error("condition held without loss");
    property p_raw; pready && !pwrite && paddr == loss_off && $stable(cable_loss)
        |-> prdata[2:0] == cable_loss; endproperty
    a_raw: assert property (p_raw) else $error("raw loss read wrong");
endmodule
////////////////////////////////////////
bind encoder_input enc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cable_loss(cable_loss), .fault_o(fault_o), .alarm_o(alarm_o));

// ===== bench/enc_model.sv
// Quadrature encoder model producing A, B and index levels.
`timescale 1ns/10ps
module enc_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Commands
    input wire logic step,
    input wire logic fwd,
    input wire logic idx,
    // Encoder channels
    output logic chan_a,
    output logic chan_b,
    output logic chan_z
);
    logic [1:0] ph_r;
    // Phase walks 00, 10, 11, 01 on A and B when turning forward.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_r <= 2'h0;
            chan_z <= 1'b0;
        end else begin
            chan_z <= idx;
            if (step) begin
                ph_r <= fwd ? ph_r + 2'h1 : ph_r - 2'h1;
            end
        end
    end
    assign chan_a = ph_r[0] ^ ph_r[1];
    assign chan_b = ph_r[1];
endmodule

// ===== bench/tb.sv
// Self-checking bench of the encoder input block.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb import enc_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q, rs = 32'he89a;
    logic pready, pslverr, err, chan_a, chan_b, chan_z, stp = 0, dr = 0, z = 0, fault_o, alarm_o;
    logic irq, sense = 0;
    logic [2:0] cable_loss = 3'h0;
    int failures = 0, compares = 0, pos = 0, ppt;
    encoder_input uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_a(chan_a), .chan_b(chan_b), .chan_z(chan_z),
        .cable_loss(cable_loss), .fault_o(fault_o), .alarm_o(alarm_o), .irq(irq));
    enc_model enc (.pclk(pclk), .presetn(presetn), .step(stp), .fwd(dr), .idx(z),
        .chan_a(chan_a), .chan_b(chan_b), .chan_z(chan_z));
    // Clock of 8 ns period.
    always #4 pclk = ~pclk;
    ////////////////////////////////////////
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    function automatic logic [31:0] efrac(int p, int m);
        return ((p % m) + m) % m;
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic steps(int n, logic f);
        repeat (n) begin
            @(posedge pclk) {stp, dr} <= {1'b1, f};
            @(posedge pclk) stp <= 1'b0;
            repeat (3) @(posedge pclk);
            pos += (f ^ sense) ? 1 : -1;
        end
        repeat (4) @(posedge pclk);
    endtask
    task automatic chk_pos();
        apb(0, frac_off, 0);
        `CHK("frac", efrac(pos, ppt), q)
        apb(0, turns_off, 0);
        `CHK("turns", 32'((pos - int'(efrac(pos, ppt))) / ppt), q)
    endtask
    task automatic end_of_test();
        if (failures == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Watchdog.
    initial begin
        #400000;
        failures++;
        end_of_test();
    end
    // Main sequence.
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, ppt_off, 0);
        `CHK("ppt reset", 32'(ppt_reset), q)
        apb(0, opt_off, 0);
        `CHK("opt reset", 32'(opt_reset), q)
        apb(0, 12'h01c, 0);
        `CHK("unmapped", 33'h100000000, {err, q})
        ppt = (xs() % 8) + 2;
        apb(1, ppt_off, ppt);
        apb(1, ppt_off, 0);
        apb(0, ppt_off, 0);
        `CHK("ppt", ppt, q)
        for (int i = 0; i < 6; i++) begin
            if (i == 3) begin
                sense = 1;
                apb(1, opt_off, 32'h80);
            end
            steps((xs() % 13) + 1, xs() & 1);
            chk_pos();
        end
        apb(1, opt_off, 32'h40);
        sense = 0;
        apb(1, stat_off, 32'hf);
        @(posedge pclk) z <= 1'b1;
        repeat (2) @(posedge pclk);
        z <= 1'b0;
        repeat (4) @(posedge pclk);
        pos = 0;
        chk_pos();
        apb(0, opt_off, 0);
        `CHK("home bit", 32'h0, q)
        apb(0, stat_off, 0);
        `CHK("stat home", 32'(1 << ev_homed), q)
        // The interrupt follows the status one edge late; look once it has settled.
        apb(1, mask_off, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK("irq set", 1'b1, irq)
        apb(1, stat_off, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK("irq clear", 1'b0, irq)
        apb(1, mask_off, 32'h0);
        for (int c = 0; c < 12; c++) begin
            apb(1, opt_off, (c % 4) << (2 * (c / 4)));
            @(posedge pclk) cable_loss <= 3'h1 << (c / 4);
            repeat (3) @(posedge pclk);
            `CHK("fault", c % 4 == 0, fault_o)
            `CHK("alarm", c % 4 == 1, alarm_o)
            apb(0, loss_off, 0);
            `CHK("loss raw", 32'(1 << (c / 4)), q)
            cable_loss <= 3'h0;
        end
        `CHK("irq masked", 1'b0, irq)
        apb(0, stat_off, 0);
        `CHK("stat loss", 32'((1 << ev_fault) | (1 << ev_alarm)), q)
        end_of_test();
    end
endmodule
